// ---- tps_pkg.sv ----
// Shared constants, carriers and states of the thermal protection supervisor
package tps_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register addresses
  localparam logic [ADDR_W-1:0] SUP_CTRL_ADDR   = 4'h0;
  localparam logic [ADDR_W-1:0] HS_CTRL_A_ADDR  = 4'h1;
  localparam logic [ADDR_W-1:0] HS_CTRL_B_ADDR  = 4'h2;
  localparam logic [ADDR_W-1:0] THERM_STAT_ADDR = 4'h3;
  localparam logic [ADDR_W-1:0] BUS_FAIL_ADDR   = 4'h4;
  localparam logic [ADDR_W-1:0] HS_OVL_ADDR     = 4'h5;
  localparam logic [ADDR_W-1:0] LIVE_ADDR       = 4'h6;

  // Supply control fields: two enable bits per auxiliary regulator
  localparam int AUX2_EN_LSB = 0;
  localparam int AUX3_EN_LSB = 2;
  localparam int EN_W        = 2;

  // High-side control: one field per switch, two switches per register
  localparam int HS_NUM     = 4;
  localparam int HS_FIELD_W = 8;

  // Thermal status bit positions
  localparam int ST_BLOCK = 0;
  localparam int ST_PW    = 1;
  localparam int ST_CHIP  = 2;
  localparam int ST_AUX2  = 3;
  localparam int ST_AUX3  = 4;
  localparam int ST_W     = 5;

  // Transceiver failure fields
  localparam int         CAN_FAIL_LSB = 0;
  localparam int         LIN_FAIL_LSB = 2;
  localparam int         FAIL_W       = 2;
  localparam logic [1:0] FAIL_OT      = 2'h1;
  localparam logic [1:0] FAIL_NONE    = 2'h0;

  // Reset values
  localparam logic [DATA_W-1:0] SUP_CTRL_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] HS_CTRL_RST   = 16'h0000;
  localparam logic [ST_W-1:0]   THERM_RST     = 5'h00;
  localparam logic [3:0]        BUS_FAIL_RST  = 4'h0;
  localparam logic [HS_NUM-1:0] HS_OVL_RST    = 4'h0;

  // Timing
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned COOL_DOWN_US = 1_000_000;
  localparam int unsigned RESTART_US   = 2_000;
  localparam int unsigned COOL_DOWN_CYC = COOL_DOWN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RESTART_CYC   = RESTART_US * (CLK_HZ / 1_000_000);

  // Comparator levels, one bit each
  typedef struct packed {
    logic              tsd_main;
    logic              pw_main;
    logic [HS_NUM-1:0] hs;
    logic              lin;
    logic              can;
    logic              aux3;
    logic              aux2;
  } tps_temp_t;

  localparam int TEMP_W = $bits(tps_temp_t);

  // Output stage enables
  typedef struct packed {
    logic              aux2_on;
    logic              aux3_on;
    logic              can_tx_en;
    logic              lin_tx_en;
    logic [HS_NUM-1:0] hs_en;
  } tps_stage_t;

  // Chip mode requests
  typedef struct packed {
    logic fail_safe;
    logic restart;
    logic normal;
  } tps_mode_t;

  typedef enum logic [1:0] {SEQ_RUN, SEQ_COOL, SEQ_RESTART} tps_seq_t;

endpackage

// ---- tps_sync.sv ----
// Three-stage synchroniser with agreement filter for one comparator level
`timescale 1ns/1ns
`default_nettype none
module tps_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic din,
  output logic      dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic out_r;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      out_r <= s3_r;
    end
  end

  assign dout = out_r;
endmodule
`default_nettype wire

// ---- tps_top.sv ----
// Thermal protection supervisor: stage shutdown, prewarning, chip shutdown sequence
// Contract
// - Tripped stage switches off independently, except the high-side switches, which go off together
// - Block flag set; clear only when cool
// - Block shutdown evaluated only while stage on
// - Aux two trip clears enables, sets status
// - Stand-alone aux three trip clears enables
// - Load-share aux three restarts when cool
// - CAN trip: transmitter off, field 01
// - LIN trip: transmitter off, field 01
// - Any high-side trip clears all switches
// - High-side status set; stay off until reconfigured
// - Diagnosis bits cleared only by software
// - Prewarning flag; clear only when cool
// - Prewarning evaluated only while main on
// - Chip trip enters fail-safe for cool-down
// - After cool-down: restart, then normal
// - Chip flag cleared only normal, cool
// - Chip shutdown evaluated only while main on
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module tps_top
  import tps_pkg::*;
#(
  parameter int unsigned COOL_CYCLES    = COOL_DOWN_CYC,
  parameter int unsigned RESTART_CYCLES = RESTART_CYC
) (
  input  wire logic              CLK,
  input  wire logic              RESETN,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  input  wire tps_temp_t         TEMP_FLAGS,
  input  wire logic              MAIN_ON,
  input  wire logic              AUX3_LOAD_SHARE,
  input  wire logic              CAN_ON,
  input  wire logic              LIN_ON,
  input  wire logic              NORMAL_MODE,
  output tps_stage_t             STAGE_EN,
  output tps_mode_t              MODE_REQ
);

  logic [TEMP_W-1:0] temp_raw;
  logic [TEMP_W-1:0] temp_lvl;
  tps_temp_t         t;
  logic [DATA_W-1:0] sup_ctrl_r;
  logic [DATA_W-1:0] hs_a_r;
  logic [DATA_W-1:0] hs_b_r;
  logic [ST_W-1:0]   therm_r;
  logic [ST_W-1:0]   therm_nxt;
  logic [3:0]        bus_fail_r;
  logic [HS_NUM-1:0] hs_ovl_r;
  logic [HS_NUM-1:0] hs_on;
  logic [HS_NUM-1:0] ot_hs;
  logic              aux2_en;
  logic              aux3_en;
  logic              ot_aux2;
  logic              ot_aux3;
  logic              ot_can;
  logic              ot_lin;
  logic              ot_block;
  logic              hot_any;
  logic              pw_q;
  logic              tsd_q;
  logic              wr_sup;
  logic              wr_hsa;
  logic              wr_hsb;
  logic              wr_stat;
  logic              wr_fail;
  logic              wr_ovl;
  tps_stage_t        stage_r;
  tps_mode_t         mode_r;
  tps_seq_t          seq_r;
  tps_seq_t          seq_nxt;
  logic [31:0]       cnt_r;
  logic [31:0]       cnt_nxt;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_r;

  // Comparator inputs pass the synchroniser, one instance per bit
  assign temp_raw = TEMP_FLAGS;
  for (genvar i = 0; i < TEMP_W; i++) begin : g_sync
    tps_sync u_sync (
      .clk    (CLK),
      .resetn (RESETN),
      .din    (temp_raw[i]),
      .dout   (temp_lvl[i])
    );
  end
  assign t = tps_temp_t'(temp_lvl);

  // A high-side switch counts as on while its control field is nonzero
  for (genvar i = 0; i < HS_NUM; i++) begin : g_hs_on
    if (i < 2) begin : g_a
      assign hs_on[i] = |hs_a_r[i*HS_FIELD_W +: HS_FIELD_W];
    end else begin : g_b
      assign hs_on[i] = |hs_b_r[(i-2)*HS_FIELD_W +: HS_FIELD_W];
    end
  end

  // Qualified trips: a block is only watched while it is switched on
  assign aux2_en  = |sup_ctrl_r[AUX2_EN_LSB +: EN_W];
  assign aux3_en  = |sup_ctrl_r[AUX3_EN_LSB +: EN_W];
  assign ot_aux2  = t.aux2 & aux2_en;
  assign ot_aux3  = t.aux3 & aux3_en;
  assign ot_can   = t.can & CAN_ON;
  assign ot_lin   = t.lin & LIN_ON;
  assign ot_hs    = t.hs & hs_on;
  assign ot_block = ot_aux2 | ot_aux3 | ot_can | ot_lin | (|ot_hs);
  assign hot_any  = t.aux2 | t.aux3 | t.can | t.lin | (|t.hs);
  assign pw_q     = t.pw_main & MAIN_ON;
  assign tsd_q    = t.tsd_main & MAIN_ON;

  // Write decode
  assign wr_sup  = WR && (ADDR == SUP_CTRL_ADDR);
  assign wr_hsa  = WR && (ADDR == HS_CTRL_A_ADDR);
  assign wr_hsb  = WR && (ADDR == HS_CTRL_B_ADDR);
  assign wr_stat = WR && (ADDR == THERM_STAT_ADDR);
  assign wr_fail = WR && (ADDR == BUS_FAIL_ADDR);
  assign wr_ovl  = WR && (ADDR == HS_OVL_ADDR);

  // Supply enables; an aux two or stand-alone aux three trip overrides a write in the same cycle
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      sup_ctrl_r <= SUP_CTRL_RST;
    end else begin
      if (wr_sup) begin
        sup_ctrl_r <= {12'h000, WDATA[3:0]};
      end
      if (ot_aux2) begin
        sup_ctrl_r[AUX2_EN_LSB +: EN_W] <= 2'h0;
      end
      if (ot_aux3 && !AUX3_LOAD_SHARE) begin
        sup_ctrl_r[AUX3_EN_LSB +: EN_W] <= 2'h0;
      end
    end
  end

  // High-side controls; any high-side trip wipes both registers
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      hs_a_r <= HS_CTRL_RST;
      hs_b_r <= HS_CTRL_RST;
    end else if (|ot_hs) begin
      hs_a_r <= HS_CTRL_RST;
      hs_b_r <= HS_CTRL_RST;
    end else begin
      if (wr_hsa) begin
        hs_a_r <= WDATA;
      end
      if (wr_hsb) begin
        hs_b_r <= WDATA;
      end
    end
  end

  // Sticky thermal status: set wins, a write of one clears only when cool
  always_comb begin
    therm_nxt = therm_r;
    if (wr_stat && WDATA[ST_BLOCK] && !hot_any) therm_nxt[ST_BLOCK] = 1'b0;
    if (wr_stat && WDATA[ST_PW] && !t.pw_main) therm_nxt[ST_PW] = 1'b0;
    if (wr_stat && WDATA[ST_CHIP] && NORMAL_MODE && !t.tsd_main) begin
      therm_nxt[ST_CHIP] = 1'b0;
    end
    if (wr_stat && WDATA[ST_AUX2] && !t.aux2) therm_nxt[ST_AUX2] = 1'b0;
    if (wr_stat && WDATA[ST_AUX3] && !t.aux3) therm_nxt[ST_AUX3] = 1'b0;
    if (ot_block) therm_nxt[ST_BLOCK] = 1'b1;
    if (pw_q) therm_nxt[ST_PW] = 1'b1;
    if (tsd_q) therm_nxt[ST_CHIP] = 1'b1;
    if (ot_aux2) therm_nxt[ST_AUX2] = 1'b1;
    if (ot_aux3) therm_nxt[ST_AUX3] = 1'b1;
  end

  // Thermal status register
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      therm_r <= THERM_RST;
    end else begin
      therm_r <= therm_nxt;
    end
  end

  // Transceiver failure fields
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      bus_fail_r <= BUS_FAIL_RST;
    end else begin
      if (ot_can) begin
        bus_fail_r[CAN_FAIL_LSB +: FAIL_W] <= FAIL_OT;
      end else if (wr_fail && (|WDATA[CAN_FAIL_LSB +: FAIL_W]) && !t.can) begin
        bus_fail_r[CAN_FAIL_LSB +: FAIL_W] <= FAIL_NONE;
      end
      if (ot_lin) begin
        bus_fail_r[LIN_FAIL_LSB +: FAIL_W] <= FAIL_OT;
      end else if (wr_fail && (|WDATA[LIN_FAIL_LSB +: FAIL_W]) && !t.lin) begin
        bus_fail_r[LIN_FAIL_LSB +: FAIL_W] <= FAIL_NONE;
      end
    end
  end

  // High-side overload status, one sticky bit per switch
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      hs_ovl_r <= HS_OVL_RST;
    end else begin
      hs_ovl_r <= ot_hs | (hs_ovl_r & ~(wr_ovl ? (WDATA[HS_NUM-1:0] & ~t.hs) : 4'h0));
    end
  end

  // Stage enables, each stage gated only by its own trip; the high-side switches by any high-side trip
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      stage_r <= '0;
    end else begin
      stage_r.aux2_on   <= aux2_en & ~ot_aux2;
      stage_r.aux3_on   <= aux3_en & ~ot_aux3;
      stage_r.can_tx_en <= CAN_ON & ~t.can;
      stage_r.lin_tx_en <= LIN_ON & ~t.lin;
      stage_r.hs_en     <= (|ot_hs) ? 4'h0 : hs_on;
    end
  end

  // Chip shutdown sequencer: run, cool-down in fail-safe, restart, run
  always_comb begin
    seq_nxt = seq_r;
    cnt_nxt = cnt_r + 32'h1;
    unique case (seq_r)
      SEQ_RUN: begin
        cnt_nxt = 32'h0;
        if (tsd_q) seq_nxt = SEQ_COOL;
      end
      SEQ_COOL: begin
        if (cnt_r >= 32'(COOL_CYCLES - 1)) begin
          seq_nxt = SEQ_RESTART;
          cnt_nxt = 32'h0;
        end
      end
      SEQ_RESTART: begin
        if (tsd_q) begin
          seq_nxt = SEQ_COOL;
          cnt_nxt = 32'h0;
        end else if (cnt_r >= 32'(RESTART_CYCLES - 1)) begin
          seq_nxt = SEQ_RUN;
          cnt_nxt = 32'h0;
        end
      end
      default: begin
        seq_nxt = SEQ_RUN;
        cnt_nxt = 32'h0;
      end
    endcase
  end

  // Sequencer state, counter and registered mode requests
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      seq_r  <= SEQ_RUN;
      cnt_r  <= 32'h0;
      mode_r <= 3'b001;
    end else begin
      seq_r            <= seq_nxt;
      cnt_r            <= cnt_nxt;
      mode_r.fail_safe <= (seq_nxt == SEQ_COOL);
      mode_r.restart   <= (seq_nxt == SEQ_RESTART);
      mode_r.normal    <= (seq_nxt == SEQ_RUN);
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    case (ADDR)
      SUP_CTRL_ADDR:   rd_mux = sup_ctrl_r;
      HS_CTRL_A_ADDR:  rd_mux = hs_a_r;
      HS_CTRL_B_ADDR:  rd_mux = hs_b_r;
      THERM_STAT_ADDR: rd_mux = {11'h000, therm_r};
      BUS_FAIL_ADDR:   rd_mux = {12'h000, bus_fail_r};
      HS_OVL_ADDR:     rd_mux = {12'h000, hs_ovl_r};
      LIVE_ADDR:       rd_mux = {4'h0, seq_r, temp_lvl};
      default:         rd_mux = 16'h0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= RD ? rd_mux : 16'h0000;
    end
  end

  assign RDATA    = rdata_r;
  assign STAGE_EN = stage_r;
  assign MODE_REQ = mode_r;

  // Checks on the design's own behaviour
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence enter_cool_s;
    (seq_r == SEQ_RUN) && tsd_q;
  endsequence

  sequence in_cool_s;
    (seq_r == SEQ_COOL) && MODE_REQ.fail_safe && !MODE_REQ.normal;
  endsequence

  sequence cool_done_s;
    (seq_r == SEQ_COOL) && (cnt_r >= 32'(COOL_CYCLES - 1));
  endsequence

  aux2_trip_a: assert property (ot_aux2 |=> (sup_ctrl_r[AUX2_EN_LSB +: EN_W] == 2'h0)
    && !STAGE_EN.aux2_on && therm_r[ST_AUX2]) else $error("aux two trip not handled");
  block_flag_a: assert property (ot_block |=> therm_r[ST_BLOCK])
    else $error("block flag not set");
  block_hold_a: assert property ((therm_r[ST_BLOCK] && hot_any) |=> therm_r[ST_BLOCK])
    else $error("block flag cleared while hot");
  can_fail_a: assert property (ot_can |=> (bus_fail_r[CAN_FAIL_LSB +: FAIL_W] == FAIL_OT)
    && !STAGE_EN.can_tx_en) else $error("can trip not handled");
  lin_fail_a: assert property (ot_lin |=> (bus_fail_r[LIN_FAIL_LSB +: FAIL_W] == FAIL_OT)
    && !STAGE_EN.lin_tx_en) else $error("lin trip not handled");
  hs_all_off_a: assert property ((|ot_hs) |=> (hs_a_r == 16'h0000) && (hs_b_r == 16'h0000)
    && (STAGE_EN.hs_en == 4'h0) && ((hs_ovl_r & $past(ot_hs)) == $past(ot_hs)))
    else $error("high-side trip not handled");
  ls_restart_a: assert property ((AUX3_LOAD_SHARE && aux3_en && $fell(t.aux3)) |=>
    STAGE_EN.aux3_on) else $error("load-share regulator not restored");
  pw_flag_a: assert property (pw_q |=> therm_r[ST_PW])
    else $error("prewarning flag not set");
  chip_clr_a: assert property ((therm_r[ST_CHIP] && !NORMAL_MODE) |=> therm_r[ST_CHIP])
    else $error("chip flag cleared outside normal mode");
  enter_cool_a: assert property (enter_cool_s |=> in_cool_s)
    else $error("fail-safe not entered");
  leave_cool_a: assert property (cool_done_s |=> (seq_r == SEQ_RESTART) && MODE_REQ.restart)
    else $error("restart not entered after cool-down");

endmodule
`default_nettype wire

// ---- tps_host_model.sv ----
// Host model: register port master that reads and clears supervisor status
`timescale 1ns/1ns
`default_nettype none
module tps_host_model
  import tps_pkg::*;
(
  input  wire logic              clk,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wdata,
  output logic                   wr,
  output logic                   rd,
  input  wire logic [DATA_W-1:0] rdata
);
  // Idle bus at time zero
  initial begin
    addr  = '0;
    wdata = '0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // One-cycle write; data lines turn over once the strobe is gone
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask

  // One-cycle read; data taken in the following cycle only
  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  // Clear the stale mark first so a new trip is not hidden behind it
  task automatic aux3_enable();
    reg_wr(THERM_STAT_ADDR, 16'h0001 << ST_AUX3);
    reg_wr(SUP_CTRL_ADDR, 16'h0003 << AUX3_EN_LSB);
  endtask
endmodule
`default_nettype wire

// ---- tb_thermal_protection_supervisor.sv ----
// Testbench: stage shutdown, prewarning and chip shutdown checks
`timescale 1ns/1ns
`default_nettype none
module tb_thermal_protection_supervisor
  import tps_pkg::*;
;
  localparam int unsigned COOL    = 20;
  localparam int unsigned RESTART = 10;
  logic              clk;
  logic              resetn;
  logic              main_on;
  logic              load_share;
  logic              can_on;
  logic              lin_on;
  logic              normal_mode;
  tps_temp_t         temp;
  tps_stage_t        stage_en;
  tps_mode_t         mode_req;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rv;
  int                err_total;
  int                n_checks;
  int                cycles;

  // Device under test with short cool-down and restart counts
  tps_top #(.COOL_CYCLES(COOL), .RESTART_CYCLES(RESTART)) u_dut (
    .CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .TEMP_FLAGS(temp),
    .MAIN_ON(main_on), .AUX3_LOAD_SHARE(load_share), .CAN_ON(can_on),
    .LIN_ON(lin_on), .NORMAL_MODE(normal_mode), .STAGE_EN(stage_en),
    .MODE_REQ(mode_req)
  );

  // Host on the register port
  tps_host_model u_host (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
  );

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    u_host.reg_rd(a, rv);
    chk(what, rv, exp);
  endtask

  // Apply comparator levels and wait past the synchroniser
  task automatic heat(input tps_temp_t f);
    @(posedge clk);
    temp <= f;
    repeat (7) @(posedge clk);
  endtask

  task automatic close_out();
    $display("Checks made %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Aux two trip, sticky diagnosis, clear refused while hot
  task automatic t_aux2();
    u_host.reg_wr(SUP_CTRL_ADDR, 16'h000f);
    heat(tps_temp_t'(10'h001));
    chk("aux2 on", stage_en.aux2_on, 1'b0);
    chk("aux3 on", stage_en.aux3_on, 1'b1);
    rd_chk("sup ctrl", SUP_CTRL_ADDR, 16'h000c);
    rd_chk("status", THERM_STAT_ADDR, 16'h0009);
    u_host.reg_wr(THERM_STAT_ADDR, 16'h001f);
    rd_chk("status hot", THERM_STAT_ADDR, 16'h0009);
    heat('0);
    rd_chk("status kept", THERM_STAT_ADDR, 16'h0009);
    chk("aux2 stays", stage_en.aux2_on, 1'b0);
    u_host.reg_wr(THERM_STAT_ADDR, 16'h001f);
    rd_chk("status clr", THERM_STAT_ADDR, 16'h0000);
  endtask

  // Aux three stand-alone and load-sharing
  task automatic t_aux3();
    heat(tps_temp_t'(10'h002));
    chk("aux3 off", stage_en.aux3_on, 1'b0);
    rd_chk("sup ctrl", SUP_CTRL_ADDR, 16'h0000);
    rd_chk("status", THERM_STAT_ADDR, 16'h0011);
    heat('0);
    @(posedge clk);
    load_share <= 1'b1;
    u_host.aux3_enable();
    heat(tps_temp_t'(10'h002));
    chk("ls off", stage_en.aux3_on, 1'b0);
    rd_chk("ls status", THERM_STAT_ADDR, 16'h0011);
    heat('0);
    chk("ls back", stage_en.aux3_on, 1'b1);
    u_host.reg_wr(THERM_STAT_ADDR, 16'h001f);
    u_host.reg_wr(SUP_CTRL_ADDR, 16'h0000);
  endtask

  // CAN then LIN: ignored while off, receive-only while hot
  task automatic t_bus();
    tps_temp_t f;
    int        lsb;
    for (int i = 0; i < 2; i++) begin
      f = (i == 0) ? tps_temp_t'(10'h004) : tps_temp_t'(10'h008);
      lsb = (i == 0) ? CAN_FAIL_LSB : LIN_FAIL_LSB;
      heat(f);
      rd_chk("fail idle", BUS_FAIL_ADDR, 16'h0000);
      rd_chk("status idle", THERM_STAT_ADDR, 16'h0000);
      heat('0);
      @(posedge clk);
      can_on <= (i == 0);
      lin_on <= (i == 1);
      heat(f);
      chk("tx off", (i == 0) ? stage_en.can_tx_en : stage_en.lin_tx_en, 1'b0);
      rd_chk("fail field", BUS_FAIL_ADDR, 16'(FAIL_OT) << lsb);
      heat('0);
      chk("tx back", (i == 0) ? stage_en.can_tx_en : stage_en.lin_tx_en, 1'b1);
      u_host.reg_wr(BUS_FAIL_ADDR, 16'h000f);
      u_host.reg_wr(THERM_STAT_ADDR, 16'h001f);
      rd_chk("fail clr", BUS_FAIL_ADDR, 16'h0000);
    end
  endtask

  // One hot switch takes all switches down
  task automatic t_hs();
    u_host.reg_wr(HS_CTRL_A_ADDR, 16'h0101);
    u_host.reg_wr(HS_CTRL_B_ADDR, 16'h0101);
    repeat (2) @(posedge clk);
    chk("hs on", stage_en.hs_en, 4'hf);
    heat(tps_temp_t'(10'h040));
    chk("hs off", stage_en.hs_en, 4'h0);
    rd_chk("ctrl a", HS_CTRL_A_ADDR, 16'h0000);
    rd_chk("ctrl b", HS_CTRL_B_ADDR, 16'h0000);
    rd_chk("ovl sw2", HS_OVL_ADDR, 16'h0004);
    heat('0);
    chk("hs stay off", stage_en.hs_en, 4'h0);
    rd_chk("ovl kept", HS_OVL_ADDR, 16'h0004);
    u_host.reg_wr(HS_CTRL_A_ADDR, 16'h0001);
    repeat (2) @(posedge clk);
    chk("hs again", stage_en.hs_en, 4'h1);
    u_host.reg_wr(HS_OVL_ADDR, 16'h000f);
    rd_chk("ovl clr", HS_OVL_ADDR, 16'h0000);
    u_host.reg_wr(THERM_STAT_ADDR, 16'h001f);
    u_host.reg_wr(HS_CTRL_A_ADDR, 16'h0000);
  endtask

  // Prewarning gated by the main supply
  task automatic t_prewarn();
    heat(tps_temp_t'(10'h100));
    rd_chk("pw off", THERM_STAT_ADDR, 16'h0000);
    @(posedge clk);
    main_on <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk("pw set", THERM_STAT_ADDR, 16'h0002);
    u_host.reg_wr(THERM_STAT_ADDR, 16'h001f);
    rd_chk("pw hot", THERM_STAT_ADDR, 16'h0002);
    heat('0);
    u_host.reg_wr(THERM_STAT_ADDR, 16'h001f);
    rd_chk("pw clr", THERM_STAT_ADDR, 16'h0000);
  endtask

  // Chip shutdown: fail-safe, restart, normal, then flag clear
  task automatic t_chip();
    int n;
    @(posedge clk);
    main_on <= 1'b0;
    heat(tps_temp_t'(10'h200));
    chk("no trip", mode_req, 3'b001);
    @(posedge clk);
    main_on <= 1'b1;
    @(posedge clk);
    temp <= '0;
    n = 0;
    while (mode_req.fail_safe !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk("fail safe", mode_req, 3'b100);
    n = 0;
    while (mode_req === 3'b100 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("cool len", 16'(n), 16'(COOL));
    chk("restart", mode_req, 3'b010);
    n = 0;
    while (mode_req === 3'b010 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("restart len", 16'(n), 16'(RESTART));
    chk("normal", mode_req, 3'b001);
    rd_chk("chip flag", THERM_STAT_ADDR, 16'h0004);
    u_host.reg_wr(THERM_STAT_ADDR, 16'h001f);
    rd_chk("chip kept", THERM_STAT_ADDR, 16'h0004);
    @(posedge clk);
    normal_mode <= 1'b1;
    u_host.reg_wr(THERM_STAT_ADDR, 16'h001f);
    rd_chk("chip clr", THERM_STAT_ADDR, 16'h0000);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end

  // Main sequence
  initial begin
    resetn      = 1'b0;
    temp        = '0;
    main_on     = 1'b0;
    load_share  = 1'b0;
    can_on      = 1'b0;
    lin_on      = 1'b0;
    normal_mode = 1'b0;
    err_total   = 0;
    n_checks    = 0;
    cycles      = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_aux2();
    t_aux3();
    t_bus();
    t_hs();
    t_prewarn();
    t_chip();
    close_out();
  end
endmodule
`default_nettype wire
